// ===== drive_status_pkg.sv
/*
  Constants and carrier types for the diskette drive status block.
  Assumes a 125 MHz clock; all cycle counts are derived from printed times.
*/
package drive_status_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int REV_TIME_US = 166670;   // One revolution, microseconds
  localparam int IDX_WIDTH_US = 1800;    // Index pulse width, microseconds
  localparam int REV_CYCLES = REV_TIME_US * CLK_MHZ;
  localparam int IDX_CYCLES = IDX_WIDTH_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Ready counting
  // ---------------------------------------------------------------
  localparam logic [1:0] HOLES_ONE_SIDED = 2'h2;
  localparam logic [1:0] HOLES_TWO_SIDED = 2'h3;

  // ---------------------------------------------------------------
  // Read stream word carried through the FIFO
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clk_bit;   // Transition at a clock window
    logic data_bit;  // Transition at a data window
  } read_word_t;

  localparam int READ_WORD_W = 2;

  // Media status as sensed from the mechanism
  typedef struct packed {
    logic present;     // Diskette in and door closed
    logic two_sided;
    logic protect;
  } media_t;

endpackage

// ===== read_fifo.sv
/*
  Synchronous FIFO with valid/ready handshakes on both sides.
  Assumes a single clock, synchronous active-high reset and clock enable.
*/
`timescale 1ns/100ps
module read_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty straight from the occupancy count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH)) && clk_en;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && clk_en;

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_r <= wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== drive_status.sv
/*
  Output logic of a diskette drive: ready, index, raw read, separated
  data and clock, write protect and write inhibit. Drive outputs active low; rd_ready active high.
  Assumes sensor inputs are asynchronous and the read stream decoder
  upstream delivers one transition per word on the drive clock.
*/
`timescale 1ns/100ps

// Behaviour
// - After insert with door closed, ready only after two index holes.
// - After power-up, withhold ready until the required holes are sensed.
// - Two-sided diskettes need three index holes before ready.
// - Single-sided: ready active on side zero, inactive on side one.
// - Two-sided: ready active on either side.
// - Raw read line idles high, pulses low per detected transition.
// - Sector variant separates data bits onto their own low pulse line.
// - Sector variant separates clock bits onto their own low pulse line.
// - Write-protect output low when diskette protected, high otherwise.
// - Standard configuration suppresses writing to a protected diskette.
// - Only a selected drive responds and drives its outputs.
// - Index pulses low 1.8 ms once per 166.67 ms revolution.
module drive_status #(
  parameter int REV_CYC = drive_status_pkg::REV_CYCLES,
  parameter int IDX_CYC = drive_status_pkg::IDX_CYCLES,
  parameter bit SECTOR_VARIANT = 1'b1,
  parameter bit INHIBIT_PROTECTED = 1'b1,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic select_n,
  input wire logic side_one,
  input wire drive_status_pkg::media_t media,
  input wire logic write_gate_n,
  input wire logic write_data_in_n,
  input wire drive_status_pkg::read_word_t rd_word,
  input wire logic rd_valid,
  output logic rd_ready,
  output logic ready_n,
  output logic index_n,
  output logic read_data_n,
  output logic separated_data_out_n,
  output logic separated_clock_out_n,
  output logic write_protect_n,
  output logic head_write_n
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic sel;
  logic side1;
  logic present;
  logic two_sided;
  logic protect;

  // Two flops on every asynchronous pin
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (clk_en) begin
      sync1_r <= {~select_n, side_one, media.present, media.two_sided, media.protect};
      sync2_r <= sync1_r;
    end
  end
  assign {sel, side1, present, two_sided, protect} = sync2_r;

  // ---------------------------------------------------------------
  // Revolution timer and index pulse
  // ---------------------------------------------------------------
  logic [31:0] rev_r;
  logic idx_r;
  logic hole;

  assign hole = present && (rev_r == 32'h0000_0000);

  // Spindle position counter, only while a diskette turns
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rev_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!present || rev_r == 32'(REV_CYC - 1)) begin
        rev_r <= 32'h0000_0000;
      end else begin
        rev_r <= rev_r + 32'h0000_0001;
      end
    end
  end

  // Index low for the pulse width at each hole
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idx_r <= 1'b0;
    end else if (clk_en) begin
      idx_r <= present && (rev_r < 32'(IDX_CYC));
    end
  end

  // ---------------------------------------------------------------
  // Ready counting
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RDY_COUNT = 2'h1,
    RDY_DONE = 2'h2
  } rdy_state_t;

  rdy_state_t rdy_r;
  logic [1:0] holes_r;
  logic [1:0] need;

  assign need = two_sided ? drive_status_pkg::HOLES_TWO_SIDED
                          : drive_status_pkg::HOLES_ONE_SIDED;

  // Count holes from reset or insertion; removal restarts
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdy_r <= RDY_COUNT;
      holes_r <= 2'h0;
    end else if (clk_en) begin
      if (!present) begin
        rdy_r <= RDY_COUNT;
        holes_r <= 2'h0;
      end else begin
        case (rdy_r)
          RDY_COUNT: begin
            if (hole) begin
              holes_r <= holes_r + 2'h1;
              if (holes_r + 2'h1 >= need) begin
                rdy_r <= RDY_DONE;
              end
            end
          end
          RDY_DONE: begin
            holes_r <= holes_r;
          end
          default: begin
            rdy_r <= RDY_COUNT;
            holes_r <= 2'h0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Read stream path through the FIFO
  // ---------------------------------------------------------------
  drive_status_pkg::read_word_t fifo_word;
  logic fifo_valid;
  logic reading;
  logic rd_pulse_r;
  logic sd_pulse_r;
  logic sc_pulse_r;

  // FIFO pops and read pulses run only when selected and not writing
  assign reading = sel && write_gate_n;

  read_fifo #(
    .WIDTH(drive_status_pkg::READ_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_data(rd_word),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(reading)
  );

  // One-cycle low pulses per popped word that carries a transition
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_pulse_r <= 1'b0;
      sd_pulse_r <= 1'b0;
      sc_pulse_r <= 1'b0;
    end else if (clk_en) begin
      rd_pulse_r <= reading && fifo_valid && (fifo_word.clk_bit || fifo_word.data_bit);
      sd_pulse_r <= SECTOR_VARIANT && reading && fifo_valid && fifo_word.data_bit;
      sc_pulse_r <= SECTOR_VARIANT && reading && fifo_valid && fifo_word.clk_bit;
    end
  end

  // ---------------------------------------------------------------
  // Output stage, gated by select
  // ---------------------------------------------------------------
  logic rdy_act;
  assign rdy_act = (rdy_r == RDY_DONE) && present && (two_sided || !side1);

  // Registered open-collector style outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ready_n <= 1'b1;
      index_n <= 1'b1;
      read_data_n <= 1'b1;
      separated_data_out_n <= 1'b1;
      separated_clock_out_n <= 1'b1;
      write_protect_n <= 1'b1;
      head_write_n <= 1'b1;
    end else if (clk_en) begin
      ready_n <= !(sel && rdy_act);
      index_n <= !(sel && idx_r);
      read_data_n <= !rd_pulse_r;
      separated_data_out_n <= !sd_pulse_r;
      separated_clock_out_n <= !sc_pulse_r;
      write_protect_n <= !(sel && present && protect);
      head_write_n <= !(sel && !write_gate_n && !write_data_in_n
                        && !(INHIBIT_PROTECTED && protect));
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_ready_gated: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !sel |=> ready_n) else $error("ready driven while unselected");
  a_ready_removed: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !present |=> rdy_r == RDY_COUNT && holes_r == 2'h0)
    else $error("ready count not restarted on removal");
  a_side_one_single: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && side1 && !two_sided |=> ready_n) else $error("single side one shows ready");
  a_two_side_ready: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && sel && two_sided && present && rdy_r == RDY_DONE |=> !ready_n)
    else $error("two-sided not ready");
  a_done_holes: assert property (@(posedge clock) disable iff (sys_rst)
    rdy_r == RDY_DONE |-> holes_r >= 2'h2) else $error("ready before enough holes");
  a_done_two: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(rdy_r == RDY_DONE) && two_sided |-> holes_r == 2'h3)
    else $error("two-sided ready early");
  a_protect_out: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && sel && present && protect |=> !write_protect_n) else $error("protect not shown");
  a_write_inhibit: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && protect && INHIBIT_PROTECTED |=> head_write_n) else $error("write to protected disk");
  a_raw_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !rd_pulse_r |=> read_data_n) else $error("raw read low without transition");
  a_index_start: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && present && rev_r == 32'h0000_0000 |=> idx_r) else $error("no index at hole");

  c_ready_one: cover property (@(posedge clock) $fell(ready_n) && !two_sided);
  c_ready_two: cover property (@(posedge clock) $fell(ready_n) && two_sided);
  c_separated_data_out: cover property (@(posedge clock) !separated_data_out_n);
  c_inhibit: cover property (@(posedge clock) sel && !write_gate_n && protect);
endmodule

// ===== host_ctrl_model.sv
/*
  Controller-side model that watches the drive's index line.
  Assumes the drive outputs are sampled on the shared drive clock.
*/
`timescale 1ns/100ps
module host_ctrl_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic index_n,
  output int pulse_count,
  output int last_width
);
  int run;
  logic prev_n;

  // Count index pulses and measure the length of each low period
  always @(posedge clock) begin
    if (sys_rst) begin
      pulse_count <= 0;
      last_width <= 0;
      run <= 0;
      prev_n <= 1'b1;
    end else begin
      prev_n <= index_n;
      if (prev_n && !index_n) begin
        pulse_count <= pulse_count + 1;
        run <= 1;
      end else if (!index_n) begin
        run <= run + 1;
      end else if (!prev_n) begin
        last_width <= run;
      end
    end
  end
endmodule

// ===== drive_status_test.sv
/*
  Self-checking bench for the drive status block.
  Assumes short revolution counts so that ready arrives within hundreds of cycles.
*/
`timescale 1ns/100ps
module drive_status_test;
  localparam int REV = 100;
  localparam int IDX = 10;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic select_n = 1'b1;
  logic side_one = 1'b0;
  drive_status_pkg::media_t media = 3'h0;
  logic write_gate_n = 1'b1;
  logic write_data_in_n = 1'b1;
  drive_status_pkg::read_word_t rd_word = 2'h0;
  logic rd_valid = 1'b0;
  logic rd_ready, ready_n, index_n, read_data_n, sep_d_n, sep_c_n, write_protect_n, head_write_n;
  logic alt_rd_n, alt_sd_n, alt_sc_n, alt_hw_n;
  int n_fail = 0;
  int n_checks = 0;
  int idx_count, idx_width, c0, n_taken;
  logic taken;
  logic [1:0] expect_q[$];

  drive_status #(.REV_CYC(REV), .IDX_CYC(IDX)) uut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .select_n(select_n), .side_one(side_one), .media(media), .write_gate_n(write_gate_n),
    .write_data_in_n(write_data_in_n), .rd_word(rd_word), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .ready_n(ready_n), .index_n(index_n), .read_data_n(read_data_n), .separated_data_out_n(sep_d_n),
    .separated_clock_out_n(sep_c_n), .write_protect_n(write_protect_n), .head_write_n(head_write_n));

  // Second drive without separator that allows writes to protected media
  drive_status #(.REV_CYC(REV), .IDX_CYC(IDX), .SECTOR_VARIANT(1'b0), .INHIBIT_PROTECTED(1'b0)) alt (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .select_n(select_n), .side_one(side_one),
    .media(media), .write_gate_n(write_gate_n), .write_data_in_n(write_data_in_n), .rd_word(rd_word),
    .rd_valid(rd_valid), .rd_ready(), .ready_n(), .index_n(), .read_data_n(alt_rd_n),
    .separated_data_out_n(alt_sd_n), .separated_clock_out_n(alt_sc_n), .write_protect_n(),
    .head_write_n(alt_hw_n));

  host_ctrl_model host (.clock(clock), .sys_rst(sys_rst), .index_n(index_n), .pulse_count(idx_count),
    .last_width(idx_width));

  // Clock of 8 ns period
  always #4 clock = ~clock;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Offer one word; the caller lowers valid after the last one
  task automatic push_word(input logic [1:0] w, output logic ok);
    rd_word = w;
    rd_valid = 1'b1;
    #1;
    ok = rd_ready;
    if (ok && w != 2'h0) expect_q.push_back(w);
    @(negedge clock);
  endtask

  task automatic wait_drain();
    int k;
    for (k = 0; k < 300 && expect_q.size() > 0; k++) @(negedge clock);
    check(expect_q.size() == 0, "read pulses missing");
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Each read pulse takes the oldest noted word and compares the lines
  always @(negedge clock) begin
    if (!sys_rst && (read_data_n !== 1'b1 || sep_d_n !== 1'b1 || sep_c_n !== 1'b1
        || alt_rd_n !== 1'b1 || alt_sd_n !== 1'b1 || alt_sc_n !== 1'b1)) begin
      if (expect_q.size() == 0) begin
        check(1'b0, "unexpected read pulse");
      end else begin
        check(read_data_n === 1'b0 && {~sep_c_n, ~sep_d_n} === expect_q.pop_front(), "read pulse");
        check(alt_rd_n === 1'b0 && {alt_sc_n, alt_sd_n} === 2'h3, "variant read pulse");
      end
    end
  end

  // Watchdog
  initial begin
    #200000;
    n_fail++;
    $display("Error at %0t: timeout", $time);
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(81));
    ticks(5);
    sys_rst = 1'b0;
    media = 3'h7;
    write_gate_n = 1'b0;
    write_data_in_n = 1'b0;
    ticks(2 * REV);
    check({ready_n, index_n, write_protect_n, head_write_n} === 4'hF && idx_count == 0, "unselected");
    media = 3'h0;
    write_gate_n = 1'b1;
    write_data_in_n = 1'b1;
    ticks(5);
    select_n = 1'b0;
    ticks(5);
    check(ready_n === 1'b1, "ready without media");
    media = 3'h4;
    ticks(REV / 2);
    check(ready_n === 1'b1, "ready after one hole");
    ticks(REV / 2 + 20);
    check(ready_n === 1'b0, "not ready after two holes");
    side_one = 1'b1;
    ticks(4);
    check(ready_n === 1'b1, "single-sided side one ready");
    side_one = 1'b0;
    ticks(4);
    check(ready_n === 1'b0, "single-sided side zero");
    c0 = idx_count;
    ticks(3 * REV);
    check(idx_count - c0 >= 2 && idx_count - c0 <= 4, "index count");
    check(idx_width == IDX, "index width");
    media = 3'h0;
    ticks(4);
    check(ready_n === 1'b1, "ready held after removal");
    media = 3'h6;
    ticks(REV + REV / 2);
    check(ready_n === 1'b1, "two-sided ready after two holes");
    ticks(REV / 2 + 20);
    check(ready_n === 1'b0, "two-sided not ready");
    side_one = 1'b1;
    ticks(4);
    check(ready_n === 1'b0, "two-sided side one");
    side_one = 1'b0;
    // Clock enable low freezes the block, so a removal seen only while frozen is lost
    clk_en = 1'b0;
    media = 3'h0;
    ticks(10);
    media = 3'h6;
    clk_en = 1'b1;
    ticks(4);
    check(ready_n === 1'b0, "state moved while clock enable low");
    // A reset in mid-run withholds ready until the holes are counted again
    sys_rst = 1'b1;
    ticks(5);
    sys_rst = 1'b0;
    ticks(4);
    check(ready_n === 1'b1, "ready right after reset");
    ticks(REV + 20);
    check(ready_n === 1'b1, "ready after two holes of three");
    ticks(REV);
    check(ready_n === 1'b0, "not ready after reset and three holes");
    media = 3'h7;
    write_gate_n = 1'b0;
    write_data_in_n = 1'b0;
    ticks(4);
    check(write_protect_n === 1'b0, "protect not shown");
    check(head_write_n === 1'b1, "write on protected");
    check(alt_hw_n === 1'b0, "variant inhibited write");
    media = 3'h6;
    ticks(4);
    check(write_protect_n === 1'b1 && head_write_n === 1'b0, "write blocked");
    write_gate_n = 1'b1;
    write_data_in_n = 1'b1;
    ticks(4);
    repeat (40) push_word(2'($urandom_range(0, 3)), taken);
    rd_valid = 1'b0;
    wait_drain();
    select_n = 1'b1;
    ticks(4);
    n_taken = 0;
    repeat (20) begin
      push_word(2'h3 - 2'(n_taken % 3), taken);
      n_taken += int'(taken);
    end
    rd_valid = 1'b0;
    check(n_taken == 16, "buffer depth");
    select_n = 1'b0;
    wait_drain();
    end_of_test();
  end
endmodule
